/* verilog/msdx_defs.svh */
/*
 Constants for the memory space decoder and external bus block.
 Assumes inclusion by bare name from design files.
*/
`ifndef MSDX_DEFS_SVH
`define MSDX_DEFS_SVH
`define MSDX_SRAM_TOP      16'h03FF
`define MSDX_SRAM_AW       10
`define MSDX_ROM_TOP       16'h7FFF
`define MSDX_CLK_PER_MC    2'h3
`define MSDX_MC_FIRST      4'h1
`define MSDX_MC_MIN        4'h2
`define MSDX_MC_MAX        4'h9
`define MSDX_STRETCH_RST   4'h2
`endif

/* verilog/msdx_pkg.sv */
/*
 Types for the memory space decoder and external bus block.
 Assumes msdx_defs.svh sits on the include path.
*/
`default_nettype none
package msdx_pkg;
    typedef enum logic [1:0] {MSDX_IDLE, MSDX_STROBE, MSDX_WAIT} msdx_state_e;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } msdx_dreq_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd_n;
        logic        wr_n;
        logic        drive_n;
    } msdx_xbus_s;
endpackage
`default_nettype wire

/* verilog/msdx_decoder.sv */
/*
 Memory space decoder with on-chip data SRAM and external parallel bus.
 Holds the data-move window, the program fetch route and the strobe sequencer.
 Assumes a core on the same clock issuing one data-move or fetch request at a time,
 and that the core keeps the SRAM enable low through reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msdx_defs.svh"
// Summary of operation
// - 1 KB on-chip data SRAM at 0000H-03FFH, data moves only, never fetches.
// - SRAM enable is an input that the core holds low through reset; while clear all data moves go external.
// - External data-move length programmable from two to nine machine cycles.
// - 64 KB program space; lower 32 KB internal ROM, above goes external.
// - Machine cycle is four clocks; bus timing counts machine cycles.
// - Port 6 bit 0 serves as wait-state input from the far side.
// - Read strobe marks each external data read.
// - Write strobe marks each external data write.
// - Scratchpad and data-move SRAM are separate, never overlapping.
// - When enabled, addresses up to 03FFH hit SRAM, higher go external.
// - Fetch kept off bus only if ROM enabled and address within 32 KB.
// - Program-fetch strobe pulses on every fetch, internal or external.
module msdx_decoder
    import msdx_pkg::*;
#(
    parameter int SRAM_WORDS = 1024
)(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             onchip_sram_enable,
    input  wire logic [3:0]       stretch_mc,
    input  wire msdx_dreq_s       dreq,
    output logic                  dbusy,
    output logic                  ddone,
    output logic [7:0]            drdata,
    input  wire logic             fetch_req,
    input  wire logic [15:0]      fetch_addr,
    input  wire logic             internal_rom_disable_n,
    output logic                  fetch_external,
    output logic                  program_fetch_strobe,
    output logic [15:0]           xaddr,
    output logic [7:0]            xdata_out,
    output logic                  xdata_oe_n,
    input  wire logic [7:0]       xdata_in,
    output logic                  xrd_n,
    output logic                  xwr_n,
    input  wire logic             port6_bit0
);
    msdx_state_e st_q;
    logic [7:0]  sram_mem [SRAM_WORDS];
    logic [1:0]  clk_q;
    logic [3:0]  mc_q;
    logic        wait_s1_q;
    logic        wait_s2_q;
    logic        ea_s1_q;
    logic        ea_s2_q;
    logic [7:0]  xin_s1_q;
    logic [7:0]  xin_s2_q;
    logic        wr_q;
    logic [3:0]  len;
    logic        take_int;
    logic        take_ext;
    logic        mc_end;
    logic        finish;

    // Window test only; the scratchpad has its own port in the core, so no overlap
    function automatic logic hits_sram(input logic en, input logic [15:0] a);
        return en && (a <= `MSDX_SRAM_TOP);
    endfunction

    // Out-of-range settings clamp rather than fault, so every access still ends
    always_comb begin
        len = stretch_mc;
        if (stretch_mc < `MSDX_MC_MIN) len = `MSDX_MC_MIN;
        if (stretch_mc > `MSDX_MC_MAX) len = `MSDX_MC_MAX;
    end

    // Request decode shared by the sequencer blocks
    always_comb begin
        take_int = (st_q == MSDX_IDLE) && dreq.req && hits_sram(onchip_sram_enable, dreq.addr);
        take_ext = (st_q == MSDX_IDLE) && dreq.req && !hits_sram(onchip_sram_enable, dreq.addr);
        mc_end   = (st_q == MSDX_STROBE) && (clk_q == `MSDX_CLK_PER_MC) && (mc_q >= len);
        finish   = (mc_end && wait_s2_q) || ((st_q == MSDX_WAIT) && wait_s2_q);
    end

    // Wait pin; resets released so no stretch is seen before the first access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_s1_q <= 1'b1;
            wait_s2_q <= 1'b1;
        end else begin
            wait_s1_q <= port6_bit0;
            wait_s2_q <= wait_s1_q;
        end
    end

    // ROM select pin; resets to the internal-fetch level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ea_s1_q <= 1'b1;
            ea_s2_q <= 1'b1;
        end else begin
            ea_s1_q <= internal_rom_disable_n;
            ea_s2_q <= ea_s1_q;
        end
    end

    // Data bus; only taken after the strobe has stood long enough to settle it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xin_s1_q <= 8'h00;
            xin_s2_q <= 8'h00;
        end else begin
            xin_s1_q <= xdata_in;
            xin_s2_q <= xin_s1_q;
        end
    end

    // On-chip SRAM, one cycle; no fetch path reaches it
    always_ff @(posedge clock) begin
        if (take_int && dreq.wr) begin
            sram_mem[dreq.addr[`MSDX_SRAM_AW-1:0]] <= dreq.wdata;
        end
    end

    // Fetch strobe follows every fetch, internal or external
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_fetch_strobe <= 1'b0;
        end else begin
            program_fetch_strobe <= fetch_req;
        end
    end

    // Fetch route; the select pin is synchronised, so a change takes three clocks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_external <= 1'b0;
        end else begin
            fetch_external <= fetch_req && (!ea_s2_q || fetch_addr > `MSDX_ROM_TOP);
        end
    end

    // Access state; wait is read from the last programmed clock on, then every clock in MSDX_WAIT, so a late release costs cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= MSDX_IDLE;
        end else begin
            unique case (st_q)
                MSDX_IDLE: begin
                    if (take_ext) st_q <= MSDX_STROBE;
                end
                MSDX_STROBE: begin
                    if (mc_end) st_q <= wait_s2_q ? MSDX_IDLE : MSDX_WAIT;
                end
                MSDX_WAIT: begin
                    if (wait_s2_q) st_q <= MSDX_IDLE;
                end
                default: st_q <= MSDX_IDLE;
            endcase
        end
    end

    // Clock within the machine cycle and machine cycles elapsed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 2'h0;
            mc_q  <= 4'h0;
        end else if (take_ext) begin
            clk_q <= 2'h0;
            mc_q  <= `MSDX_MC_FIRST;
        end else if (st_q == MSDX_STROBE) begin
            clk_q <= clk_q + 2'h1;
            if (clk_q == `MSDX_CLK_PER_MC && !mc_end) mc_q <= mc_q + 4'h1;
        end
    end

    // Address, data and strobe frozen from take to finish
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_q       <= 1'b0;
            xaddr      <= 16'h0000;
            xdata_out  <= 8'h00;
            xdata_oe_n <= 1'b1;
            xrd_n      <= 1'b1;
            xwr_n      <= 1'b1;
        end else if (take_ext) begin
            wr_q       <= dreq.wr;
            xaddr      <= dreq.addr;
            xdata_out  <= dreq.wdata;
            xdata_oe_n <= !dreq.wr;
            xrd_n      <= dreq.wr;
            xwr_n      <= !dreq.wr;
        end else if (finish) begin
            xdata_oe_n <= 1'b1;
            xrd_n      <= 1'b1;
            xwr_n      <= 1'b1;
        end
    end

    // Core handshake; done is a single-cycle pulse for either path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dbusy <= 1'b0;
            ddone <= 1'b0;
        end else begin
            dbusy <= take_ext || (dbusy && !finish);
            ddone <= take_int || finish;
        end
    end

    // Read data holds until the next read completes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drdata <= 8'h00;
        end else if (take_int && !dreq.wr) begin
            drdata <= sram_mem[dreq.addr[`MSDX_SRAM_AW-1:0]];
        end else if (finish && !wr_q) begin
            drdata <= xin_s2_q;
        end
    end
endmodule // msdx_decoder
`default_nettype wire

/* tb/msdx_sva.sv */
/* Port checker for msdx_decoder, bound to every instance.
   Assumes one clock and the async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module msdx_sva
    import msdx_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        onchip_sram_enable,
    input wire logic        dbusy,
    input wire logic        ddone,
    input wire logic        fetch_req,
    input wire logic        fetch_external,
    input wire logic        program_fetch_strobe,
    input wire logic        xdata_oe_n,
    input wire logic        xrd_n,
    input wire logic        xwr_n,
    input wire msdx_dreq_s  dreq,
    input wire logic [15:0] fetch_addr,
    input wire logic [15:0] xaddr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_excl; !(!xrd_n && !xwr_n); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_woe; !xwr_n |-> !xdata_oe_n; endproperty
    a_woe: assert property (p_woe) else $error("write data not driven");
    property p_pfs; fetch_req |=> program_fetch_strobe; endproperty
    a_pfs: assert property (p_pfs) else $error("no fetch strobe");
    property p_rom; fetch_req && fetch_addr > 16'h7FFF |=> fetch_external; endproperty
    a_rom: assert property (p_rom) else $error("high fetch kept inside");
    property p_hold; !(xrd_n && xwr_n) && $past(!(xrd_n && xwr_n)) |-> $stable(xaddr); endproperty
    a_hold: assert property (p_hold) else $error("address moved");
    property p_min; $fell(xrd_n && xwr_n) |-> !(xrd_n && xwr_n) [*8]; endproperty
    a_min: assert property (p_min) else $error("strobe too short");
    property p_sram;
        dreq.req && !dbusy && !ddone && onchip_sram_enable && dreq.addr <= 16'h03FF
        |=> ddone && xrd_n && xwr_n;
    endproperty
    a_sram: assert property (p_sram) else $error("window access left chip");
    property p_ext;
        dreq.req && !dbusy && !ddone && (!onchip_sram_enable || dreq.addr > 16'h03FF)
        |=> dbusy && xaddr == $past(dreq.addr) && (xrd_n ^ xwr_n);
    endproperty
    a_ext: assert property (p_ext) else $error("external access missing");
    property p_end; $rose(xrd_n && xwr_n) |-> ddone && !dbusy; endproperty
    a_end: assert property (p_end) else $error("strobe end without done");
endmodule // msdx_sva
bind msdx_decoder msdx_sva chk_u(.clock(clock), .rst_n(rst_n), .onchip_sram_enable(onchip_sram_enable),
    .dbusy(dbusy), .ddone(ddone), .fetch_req(fetch_req), .fetch_external(fetch_external),
    .program_fetch_strobe(program_fetch_strobe), .xdata_oe_n(xdata_oe_n), .xrd_n(xrd_n), .xwr_n(xwr_n),
    .dreq(dreq), .fetch_addr(fetch_addr), .xaddr(xaddr));
`default_nettype wire

/* tb/msdx_xmem.sv */
/* External memory model on the far side of the data bus.
   Assumes active-low strobes; slow stretches accesses with the wait line. */
`timescale 1ns/1ns
`default_nettype none
module msdx_xmem (
    input  wire logic        clock,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        slow,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    output logic [7:0]       rdata,
    output logic             wait_n
);
    logic [7:0] m [65536];
    logic [7:0] pat = 8'h3C;
    logic [3:0] k = 4'h0;
    always @(posedge clock) begin
        pat <= ~pat;
        k <= (rd_n && wr_n) ? 4'h0 : k + {3'h0, k != 4'hF};
        if (!wr_n) m[addr] <= wdata;
    end
    // Released bus toggles so stale data never looks valid
    assign rdata = rd_n ? pat : m[addr];
    assign wait_n = !(slow && !(rd_n && wr_n) && k < 4'hC);
endmodule // msdx_xmem
`default_nettype wire

/* tb/testbench.sv */
/* Self-checking bench for msdx_decoder with an external memory model.
   Assumes the bench drives all inputs at the falling edge. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import msdx_pkg::*;
    logic clock = 0, rst_n = 0, en = 0, fr = 0, irdn = 1, slow = 0;
    logic [3:0] st = 4'h2;
    logic [15:0] fa = 16'h0000;
    msdx_dreq_s dq = '0;
    wire logic bz, dn, fx, pfs, rd, wr, w;
    wire logic [7:0] rdat, xo, xi;
    wire logic [15:0] xa;
    int errors = 0, num_checks = 0, cyc = 0;
    logic [7:0] sb [int];
    logic [15:0] ca [4] = '{16'h0000, 16'h03FF, 16'h0400, 16'hFFFF};
    logic [3:0] cs [6] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'hA, 4'hF};
    always #20 clock = ~clock;
    msdx_decoder dut_u(.clock(clock), .rst_n(rst_n), .onchip_sram_enable(en), .stretch_mc(st), .dreq(dq),
        .dbusy(bz), .ddone(dn), .drdata(rdat), .fetch_req(fr), .fetch_addr(fa), .internal_rom_disable_n(irdn),
        .fetch_external(fx), .program_fetch_strobe(pfs), .xaddr(xa), .xdata_out(xo), .xdata_oe_n(),
        .xdata_in(xi), .xrd_n(rd), .xwr_n(wr), .port6_bit0(w));
    msdx_xmem mem_u(.clock(clock), .rd_n(rd), .wr_n(wr), .slow(slow), .addr(xa), .wdata(xo), .rdata(xi),
        .wait_n(w));
    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        num_checks++;
        if (e !== s) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Cycles from take to done; window hits finish in one
    function automatic logic [15:0] exp_len(logic x, logic [3:0] s);
        return x ? 16'(1 + 4 * (s < 2 ? 2 : (s > 9 ? 9 : s))) : 16'h0001;
    endfunction
    task automatic mv(logic w_i, logic [15:0] a, logic [7:0] d);
        int n;
        logic x, xs;
        x = !en || a > 16'h03FF;
        xs = 0;
        @(negedge clock) dq = '{1'b1, w_i, a, d};
        @(negedge clock) dq.req = 1'b0;
        for (n = 1; dn !== 1'b1 && n < 99; n++) begin
            xs |= !(rd && wr);
            @(negedge clock);
        end
        chk("route", x, xs);
        if (slow) chk("wait_len", 1, n >= exp_len(x, st) && n < 99);
        else chk("cycles", exp_len(x, st), 16'(n));
        if (w_i) sb[{x, a}] = d;
        else if (sb.exists({x, a})) chk("rdata", sb[{x, a}], rdat);
    endtask
    task automatic fe(logic [15:0] a);
        @(negedge clock) fr = 1'b1;
        fa = a;
        @(negedge clock) fr = 1'b0;
        chk("fetch_strobe", 1, pfs);
        chk("fetch_ext", !irdn || a > 16'h7FFF, fx);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            errors++;
            wrap_up;
        end
    end
    initial begin
        void'($urandom(32'h1557bc22));
        repeat (2) @(negedge clock);
        rst_n = 1;
        chk("idle_strobes", 2'b11, {rd, wr});
        for (int e = 0; e < 2; e++) foreach (ca[i]) begin
            en = e[0];
            mv(1, ca[i], ca[i][7:0] ^ 8'h5A);
            mv(0, ca[i], 8'h00);
        end
        foreach (cs[i]) begin
            st = cs[i];
            mv(0, 16'h8000, 8'h00);
        end
        repeat (200) begin
            st = 4'($urandom);
            slow = $urandom_range(0, 3) == 0;
            en = 1'($urandom);
            mv(1'($urandom), 16'($urandom) & 16'h87FF, 8'($urandom));
        end
        repeat (80) begin
            if ($urandom_range(0, 7) == 0) begin
                irdn = ~irdn;
                repeat (3) @(negedge clock);
            end
            fe($urandom_range(0, 1) ? 16'h7FFF : 16'($urandom));
        end
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
